//--- hdl/ebrwc_top.sv
/*
 * External asynchronous memory access engine with ready-driven wait states.
 * Software programs timing and starts one access at a time over AXI4-Lite;
 * the pin side runs on the timing clock tim_clk and crosses by toggle
 * handshake. Assumes the partner meets ready setup in synchronous mode.
 */
`timescale 1ns/1ns
module ebrwc_top
	import ebrwc_pkg::*;
(
	// system clock and reset
	input wire logic clk,
	input wire logic rst,
	// interface timing clock
	input wire logic tim_clk,
	// axi4-lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// external memory pins
	output logic bus_clock_out,
	output logic zone_select_n,
	output logic [EBRWC_ADDR_W-1:0] ext_address_bus,
	output logic read_strobe_n,
	output logic write_strobe_lower_n,
	output logic write_strobe_upper_n,
	output logic read_not_write,
	output logic [EBRWC_DATA_W-1:0] data_out,
	output logic data_oe,
	input wire logic [EBRWC_DATA_W-1:0] data_in,
	input wire logic ext_ready_in
);

	ebrwc_cfg_if cfg();

	// system-domain state
	logic req_tgl_r;
	logic done_seen;
	logic done_last_r;
	logic busy;
	logic [EBRWC_DATA_W-1:0] rdata_clk_r;
	logic snap_read_r, snap_use_r, snap_mode_r, snap_dbl_r, snap_w32_r;
	logic [15:0] snap_timing_r;
	logic [EBRWC_ADDR_W-1:0] snap_addr_r;
	logic [EBRWC_DATA_W-1:0] snap_wdata_r;
	logic [6:0] rst_cnt_r;
	logic rst_long_r;

	// timing-domain state
	logic tim_rst;
	logic req_seen;
	logic req_ack_r;
	logic done_tgl_r;
	logic dbl_t_r;
	logic div_r;
	logic rdy_async;
	logic rdy_seen_r;
	logic [7:0] cnt_r;
	logic [EBRWC_DATA_W-1:0] rd_data_r;
	ebrwc_state_type state_r, state_nxt;
	logic accept;
	logic [7:0] lead, act, trail, samp_pt;
	logic rdy_val, samp_ok, act_done, lead_done, trail_done;
	logic cs_n_r, rd_n_r, we_n_r, rnw_r;
	logic [EBRWC_ADDR_W-1:0] addr_r;

	ebrwc_axi_regs u_regs (
		.clk(clk),
		.rst(rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.cfg(cfg.regs)
	);

	// busy from request toggle until the done toggle comes back
	assign busy = req_tgl_r != done_seen;
	assign cfg.busy = busy;
	assign cfg.rdata = rdata_clk_r;

	// snapshot the access so software may rewrite registers meanwhile
	always_ff @(posedge clk) begin
		if (rst) begin
			req_tgl_r <= 1'b0;
			snap_read_r <= 1'b0;
			snap_use_r <= 1'b0;
			snap_mode_r <= 1'b0;
			snap_dbl_r <= 1'b0;
			snap_w32_r <= 1'b1;
			snap_timing_r <= EBRWC_TIMING_RST;
			snap_addr_r <= '0;
			snap_wdata_r <= '0;
		end else if (cfg.start && !busy) begin
			req_tgl_r <= ~req_tgl_r;
			snap_read_r <= cfg.start_read;
			snap_use_r <= cfg.use_ready;
			snap_mode_r <= cfg.ready_mode;
			snap_dbl_r <= cfg.dbl;
			snap_w32_r <= cfg.w32;
			snap_timing_r <= cfg.timing;
			snap_addr_r <= cfg.addr;
			snap_wdata_r <= cfg.wdata;
		end
	end

	// read data is stable in the timing domain once done has crossed
	always_ff @(posedge clk) begin
		if (rst) begin
			done_last_r <= 1'b0;
			rdata_clk_r <= '0;
		end else begin
			done_last_r <= done_seen;
			if (done_seen != done_last_r) begin
				rdata_clk_r <= rd_data_r;
			end
		end
	end

	// a reset of a few clk cycles can fall between two tim_clk edges, so hold it long enough
	always_ff @(posedge clk) begin
		if (rst) begin
			rst_cnt_r <= EBRWC_RST_STRETCH;
			rst_long_r <= 1'b1;
		end else begin
			if (rst_cnt_r != 7'h00) begin
				rst_cnt_r <= rst_cnt_r - 7'h01;
			end
			rst_long_r <= rst_cnt_r != 7'h00;
		end
	end

	// crossings: reset, request and external ready into the timing domain, done back out
	ebrwc_sync u_rst_sync (.clk(tim_clk), .d(rst_long_r), .q(tim_rst));
	ebrwc_sync u_req_sync (.clk(tim_clk), .d(req_tgl_r), .q(req_seen));
	ebrwc_sync u_done_sync (.clk(clk), .d(done_tgl_r), .q(done_seen));
	ebrwc_sync u_rdy_sync (.clk(tim_clk), .d(ext_ready_in), .q(rdy_async));

	// lead of zero would break the counter, so it acts as one
	function automatic logic [7:0] lead_of(input logic [EBRWC_LEAD_W-1:0] f);
		lead_of = (f == '0) ? 8'h01 : {6'h0, f};
	endfunction

	// per-direction timing fields
	always_comb begin
		if (snap_read_r) begin
			lead = lead_of(snap_timing_r[EBRWC_RD_LEAD_LSB +: EBRWC_LEAD_W]);
			act = {5'h0, snap_timing_r[EBRWC_RD_ACT_LSB +: EBRWC_ACT_W]};
			trail = {6'h0, snap_timing_r[EBRWC_RD_TRAIL_LSB +: EBRWC_TRAIL_W]};
		end else begin
			lead = lead_of(snap_timing_r[EBRWC_WR_LEAD_LSB +: EBRWC_LEAD_W]);
			act = {5'h0, snap_timing_r[EBRWC_WR_ACT_LSB +: EBRWC_ACT_W]};
			trail = {6'h0, snap_timing_r[EBRWC_WR_TRAIL_LSB +: EBRWC_TRAIL_W]};
		end
	end

	// ready sampling point, counted within the active period
	always_comb begin
		samp_pt = (act == 8'h00) ? 8'h00 : act - 8'h01;
		if (snap_mode_r) begin
			samp_pt = (samp_pt > EBRWC_ASYNC_EARLY) ? samp_pt - EBRWC_ASYNC_EARLY : 8'h00;
		end
	end

	// mode selects sampler; sync mode relies on the partner's setup window
	assign rdy_val = snap_mode_r ? rdy_async : ext_ready_in;
	assign samp_ok = snap_use_r && (cnt_r >= samp_pt);
	assign lead_done = cnt_r >= lead - 8'h01;
	assign trail_done = cnt_r >= trail - 8'h01;
	assign act_done = (act == 8'h00 || cnt_r >= act - 8'h01) &&
		(!snap_use_r || rdy_seen_r || (samp_ok && rdy_val));
	assign accept = (state_r == EBRWC_IDLE) && (req_seen != req_ack_r);

	// access sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			EBRWC_IDLE: begin
				if (accept) begin
					state_nxt = (snap_dbl_r && dbl_t_r && div_r) ? EBRWC_ALIGN : EBRWC_LEAD;
				end
			end
			EBRWC_ALIGN: state_nxt = EBRWC_LEAD;
			EBRWC_LEAD: begin
				if (lead_done) begin
					state_nxt = EBRWC_ACTIVE;
				end
			end
			EBRWC_ACTIVE: begin
				if (act_done) begin
					state_nxt = (trail == 8'h00) ? EBRWC_IDLE : EBRWC_TRAIL;
				end
			end
			EBRWC_TRAIL: begin
				if (trail_done) begin
					state_nxt = EBRWC_IDLE;
				end
			end
			default: state_nxt = EBRWC_IDLE;
		endcase
	end

	// state, phase counter and handshake toggles
	always_ff @(posedge tim_clk) begin
		if (tim_rst) begin
			state_r <= EBRWC_IDLE;
			cnt_r <= 8'h00;
			req_ack_r <= 1'b0;
			done_tgl_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (state_nxt != state_r) begin
				cnt_r <= 8'h00;
			end else if (cnt_r != 8'hFF) begin
				cnt_r <= cnt_r + 8'h01;
			end
			if (accept) begin
				req_ack_r <= req_seen;
			end
			if (state_r != EBRWC_IDLE && state_nxt == EBRWC_IDLE) begin
				done_tgl_r <= ~done_tgl_r;
			end
		end
	end

	// ready found high, held until the active period may end
	always_ff @(posedge tim_clk) begin
		if (tim_rst || state_r != EBRWC_ACTIVE) begin
			rdy_seen_r <= 1'b0;
		end else if (samp_ok && rdy_val) begin
			rdy_seen_r <= 1'b1;
		end
	end

	// bus clock divider; mode changes only at the start of an access
	always_ff @(posedge tim_clk) begin
		if (tim_rst) begin
			dbl_t_r <= 1'b0;
			div_r <= 1'b0;
		end else begin
			if (accept) begin
				dbl_t_r <= snap_dbl_r;
			end
			div_r <= (accept ? snap_dbl_r : dbl_t_r) ? ~div_r : 1'b0;
		end
	end

	// full rate passes the timing clock straight out, trading a clock mux for no divider skew
	assign bus_clock_out = dbl_t_r ? div_r : tim_clk;

	// registered strobes, taken from the next state
	always_ff @(posedge tim_clk) begin
		if (tim_rst) begin
			cs_n_r <= 1'b1;
			rd_n_r <= 1'b1;
			we_n_r <= 1'b1;
			rnw_r <= 1'b1;
			data_oe <= 1'b0;
		end else begin
			cs_n_r <= !(state_nxt inside {EBRWC_LEAD, EBRWC_ACTIVE, EBRWC_TRAIL});
			rd_n_r <= !(state_nxt == EBRWC_ACTIVE && snap_read_r);
			we_n_r <= !(state_nxt == EBRWC_ACTIVE && !snap_read_r);
			rnw_r <= !(state_nxt inside {EBRWC_LEAD, EBRWC_ACTIVE, EBRWC_TRAIL} && !snap_read_r);
			data_oe <= state_nxt inside {EBRWC_LEAD, EBRWC_ACTIVE, EBRWC_TRAIL} && !snap_read_r;
		end
	end

	// address and write data change only at lead entry
	always_ff @(posedge tim_clk) begin
		if (tim_rst) begin
			addr_r <= '0;
			data_out <= '0;
		end else if (state_nxt == EBRWC_LEAD && state_r != EBRWC_LEAD) begin
			addr_r <= snap_addr_r;
			data_out <= snap_wdata_r;
		end
	end

	// read data captured as the read strobe rises
	always_ff @(posedge tim_clk) begin
		if (tim_rst) begin
			rd_data_r <= '0;
		end else if (state_r == EBRWC_ACTIVE && act_done && snap_read_r) begin
			rd_data_r <= snap_w32_r ? data_in : {16'h0, data_in[15:0]};
		end
	end

	assign zone_select_n = cs_n_r;
	assign ext_address_bus = addr_r;
	assign read_strobe_n = rd_n_r;
	assign write_strobe_lower_n = we_n_r;
	assign read_not_write = rnw_r;
	// upper strobe or address bit zero
	assign write_strobe_upper_n = snap_w32_r ? we_n_r : addr_r[0];

endmodule

//--- hdl/ebrwc_pkg.sv
/*
 * Shared constants and types for the external bus ready/wait controller:
 * register offsets, field positions, reset values and the access state type.
 * Assumes a 32-bit AXI4-Lite register bus and a 20-bit external address bus.
 */
package ebrwc_pkg;

	// external bus widths
	localparam int unsigned EBRWC_ADDR_W = 20;
	localparam int unsigned EBRWC_DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] EBRWC_OFF_CTRL = 8'h00;
	localparam logic [7:0] EBRWC_OFF_TIMING = 8'h04;
	localparam logic [7:0] EBRWC_OFF_ADDR = 8'h08;
	localparam logic [7:0] EBRWC_OFF_WDATA = 8'h0C;
	localparam logic [7:0] EBRWC_OFF_CMD = 8'h10;
	localparam logic [7:0] EBRWC_OFF_STATUS = 8'h14;
	localparam logic [7:0] EBRWC_OFF_RDATA = 8'h18;

	// control register fields
	localparam int unsigned EBRWC_CTRL_USE = 0;
	localparam int unsigned EBRWC_CTRL_MODE = 1;
	localparam int unsigned EBRWC_CTRL_DBL = 2;
	localparam int unsigned EBRWC_CTRL_W32 = 3;
	localparam logic [3:0] EBRWC_CTRL_RST = 4'h8;

	// timing register fields (lead 2 bits, active 3 bits, trail 2 bits)
	localparam int unsigned EBRWC_LEAD_W = 2;
	localparam int unsigned EBRWC_ACT_W = 3;
	localparam int unsigned EBRWC_TRAIL_W = 2;
	localparam int unsigned EBRWC_RD_LEAD_LSB = 0;
	localparam int unsigned EBRWC_RD_ACT_LSB = 2;
	localparam int unsigned EBRWC_RD_TRAIL_LSB = 5;
	localparam int unsigned EBRWC_WR_LEAD_LSB = 8;
	localparam int unsigned EBRWC_WR_ACT_LSB = 10;
	localparam int unsigned EBRWC_WR_TRAIL_LSB = 13;
	localparam logic [15:0] EBRWC_TIMING_RST = 16'h7F7F;

	// command register: bit 0 set means read access
	localparam int unsigned EBRWC_CMD_READ = 0;

	// system clocks that reset is stretched by, so the slow timing side surely sees it
	localparam logic [6:0] EBRWC_RST_STRETCH = 7'h40;

	// asynchronous ready is sampled this many timing cycles early
	localparam logic [7:0] EBRWC_ASYNC_EARLY = 8'h02;

	// axi responses
	localparam logic [1:0] EBRWC_RESP_OKAY = 2'h0;
	localparam logic [1:0] EBRWC_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		EBRWC_IDLE,
		EBRWC_ALIGN,
		EBRWC_LEAD,
		EBRWC_ACTIVE,
		EBRWC_TRAIL
	} ebrwc_state_type;

endpackage

//--- hdl/ebrwc_cfg_if.sv
/*
 * Carrier between the register slave and the access engine: configuration,
 * the access request and the results that software reads back.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ns
interface ebrwc_cfg_if;
	import ebrwc_pkg::*;

	logic use_ready;
	logic ready_mode;
	logic dbl;
	logic w32;
	logic [15:0] timing;
	logic [EBRWC_ADDR_W-1:0] addr;
	logic [EBRWC_DATA_W-1:0] wdata;
	logic start;
	logic start_read;
	logic busy;
	logic [EBRWC_DATA_W-1:0] rdata;

	modport regs (
		output use_ready, ready_mode, dbl, w32, timing, addr, wdata, start, start_read,
		input busy, rdata
	);
	modport core (
		input use_ready, ready_mode, dbl, w32, timing, addr, wdata, start, start_read,
		output busy, rdata
	);
endinterface

//--- hdl/ebrwc_sync.sv
/*
 * Three-stage synchroniser for a level from another clock domain.
 * The output follows only once stages two and three agree.
 * Assumes no reset: the input must hold for a few destination edges.
 */
`timescale 1ns/1ns
module ebrwc_sync (
	// destination clock
	input wire logic clk,
	// asynchronous level in, settled level out
	input wire logic d,
	output logic q
);

	logic s1_r;
	logic s2_r;
	logic s3_r;

	// chain; the first stage feeds only the second
	always_ff @(posedge clk) begin
		s1_r <= d;
		s2_r <= s1_r;
		s3_r <= s2_r;
	end

	// filter: take the value only when two stages agree
	always_ff @(posedge clk) begin
		if (s2_r == s3_r) begin
			q <= s3_r;
		end
	end

endmodule

//--- hdl/ebrwc_axi_regs.sv
/*
 * AXI4-Lite slave holding the control, timing, address, data and command
 * registers. Assumes one outstanding write and one read at a time.
 * Unmapped offsets answer SLVERR; a command while busy is dropped.
 */
`timescale 1ns/1ns
module ebrwc_axi_regs
	import ebrwc_pkg::*;
(
	// system
	input wire logic clk,
	input wire logic rst,
	// axi write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// toward the engine
	ebrwc_cfg_if.regs cfg
);

	logic aw_held_r, w_held_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [3:0] ctrl_r;
	logic [15:0] timing_r;
	logic [31:0] addr_r, wreg_r;
	logic wr_fire;

	// offset decode shared by both directions
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == EBRWC_OFF_CTRL) || (a == EBRWC_OFF_TIMING) || (a == EBRWC_OFF_ADDR) ||
			(a == EBRWC_OFF_WDATA) || (a == EBRWC_OFF_CMD) || (a == EBRWC_OFF_STATUS) ||
			(a == EBRWC_OFF_RDATA);
	endfunction

	// byte-lane merge
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
		end
	endfunction

	assign s_axi_awready = !aw_held_r;
	assign s_axi_wready = !w_held_r;
	assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

	// address and data are taken in either order, response follows both
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= EBRWC_RESP_OKAY;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_held_r) begin
				aw_held_r <= 1'b1;
				awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
			end else if (wr_fire) begin
				aw_held_r <= 1'b0;
			end
			if (s_axi_wvalid && !w_held_r) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_r <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(awaddr_r) ? EBRWC_RESP_OKAY : EBRWC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register writes; a command only starts an idle engine
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_r <= EBRWC_CTRL_RST;
			timing_r <= EBRWC_TIMING_RST;
			addr_r <= 32'h0;
			wreg_r <= 32'h0;
			cfg.start <= 1'b0;
			cfg.start_read <= 1'b0;
		end else begin
			cfg.start <= wr_fire && (awaddr_r == EBRWC_OFF_CMD) && wstrb_r[0] && !cfg.busy;
			if (wr_fire && awaddr_r == EBRWC_OFF_CMD && wstrb_r[0]) begin
				cfg.start_read <= wdata_r[EBRWC_CMD_READ];
			end
			if (wr_fire && awaddr_r == EBRWC_OFF_CTRL && wstrb_r[0]) begin
				ctrl_r <= wdata_r[3:0];
			end
			if (wr_fire && awaddr_r == EBRWC_OFF_TIMING) begin
				timing_r <= 16'(merge({16'h0, timing_r}, wdata_r, wstrb_r)) & EBRWC_TIMING_RST;
			end
			if (wr_fire && awaddr_r == EBRWC_OFF_ADDR) begin
				addr_r <= merge(addr_r, wdata_r, wstrb_r) & 32'h000FFFFF;
			end
			if (wr_fire && awaddr_r == EBRWC_OFF_WDATA) begin
				wreg_r <= merge(wreg_r, wdata_r, wstrb_r);
			end
		end
	end

	assign cfg.use_ready = ctrl_r[EBRWC_CTRL_USE];
	assign cfg.ready_mode = ctrl_r[EBRWC_CTRL_MODE];
	assign cfg.dbl = ctrl_r[EBRWC_CTRL_DBL];
	assign cfg.w32 = ctrl_r[EBRWC_CTRL_W32];
	assign cfg.timing = timing_r;
	assign cfg.addr = addr_r[EBRWC_ADDR_W-1:0];
	assign cfg.wdata = wreg_r;
	assign s_axi_arready = !s_axi_rvalid;

	// read channel; data registered at the address handshake
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= EBRWC_RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped({s_axi_araddr[7:2], 2'b00}) ? EBRWC_RESP_OKAY : EBRWC_RESP_SLVERR;
			case ({s_axi_araddr[7:2], 2'b00})
				EBRWC_OFF_CTRL: s_axi_rdata <= {28'h0, ctrl_r};
				EBRWC_OFF_TIMING: s_axi_rdata <= {16'h0, timing_r};
				EBRWC_OFF_ADDR: s_axi_rdata <= addr_r;
				EBRWC_OFF_WDATA: s_axi_rdata <= wreg_r;
				EBRWC_OFF_STATUS: s_axi_rdata <= {31'h0, cfg.busy};
				EBRWC_OFF_RDATA: s_axi_rdata <= cfg.rdata;
				default: s_axi_rdata <= 32'h0;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

//--- tb/ebrwc_assertions.sv
/* checker for the engine's pin relations and bus answers.
   assumes it is bound onto ebrwc_top; pins are sampled on the timing clock. */
`timescale 1ns/1ns
module ebrwc_checker
	import ebrwc_pkg::*;
(
	// clocks and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic tim_clk,
	// bus answers
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// memory pins
	input wire logic bus_clock_out,
	input wire logic zone_select_n,
	input wire logic [EBRWC_ADDR_W-1:0] ext_address_bus,
	input wire logic read_strobe_n,
	input wire logic write_strobe_lower_n,
	input wire logic write_strobe_upper_n,
	input wire logic read_not_write,
	input wire logic data_oe
);
	// the pin side leaves reset some tim_clk cycles after rst falls, so pin checks wait for it
	localparam int QUIET = 100;
	int settle_r = 0;
	logic quiet;
	always @(posedge clk) begin
		if (rst) begin
			settle_r <= 0;
		end else if (settle_r < QUIET) begin
			settle_r <= settle_r + 1;
		end
	end
	assign quiet = rst || (settle_r < QUIET);
	// pin relations; a divided bus clock must be rising where a lead starts
	a_lead_aligned: assert property (@(posedge tim_clk) disable iff (quiet)
		$fell(zone_select_n) && $changed(bus_clock_out) |-> bus_clock_out) else $error("lead off clock edge");
	a_lead_first: assert property (@(posedge tim_clk) disable iff (quiet)
		$fell(read_strobe_n) || $fell(write_strobe_lower_n) |-> $past(!zone_select_n)) else $error("no lead");
	a_idle_quiet: assert property (@(posedge tim_clk) disable iff (quiet)
		zone_select_n |-> read_strobe_n && write_strobe_lower_n && read_not_write && !data_oe)
		else $error("strobe outside access");
	a_addr_hold: assert property (@(posedge tim_clk) disable iff (quiet)
		$changed(ext_address_bus) |-> $fell(zone_select_n)) else $error("address moved");
	a_upper_strobe: assert property (@(posedge tim_clk) disable iff (quiet)
		write_strobe_upper_n == write_strobe_lower_n || write_strobe_upper_n == ext_address_bus[0])
		else $error("upper strobe wrong");
	a_read_dir: assert property (@(posedge tim_clk) disable iff (quiet)
		!read_strobe_n |-> read_not_write && !data_oe && !zone_select_n && write_strobe_lower_n)
		else $error("read direction");
	a_write_dir: assert property (@(posedge tim_clk) disable iff (quiet)
		!write_strobe_lower_n |-> !read_not_write && data_oe && !zone_select_n) else $error("write direction");
	// bus answers stand until taken
	a_bresp_hold: assert property (@(posedge clk) disable iff (rst)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_rdata_hold: assert property (@(posedge clk) disable iff (rst)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	c_read: cover property (@(posedge tim_clk) $fell(read_strobe_n));
	c_write: cover property (@(posedge tim_clk) $fell(write_strobe_lower_n));
	c_aligned: cover property (@(posedge tim_clk) $fell(zone_select_n) && $rose(bus_clock_out));
endmodule
bind ebrwc_top ebrwc_checker u_chk (.clk, .rst, .tim_clk, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .bus_clock_out, .zone_select_n, .ext_address_bus,
	.read_strobe_n, .write_strobe_lower_n, .write_strobe_upper_n, .read_not_write, .data_oe);

//--- tb/ebrwc_mem_model.sv
/* external memory with a ready output, four words deep.
   assumes the engine's strobes and the shared timing clock. */
`timescale 1ns/1ns
module ebrwc_mem_model (
	// timing clock and wait setting
	input wire logic tim_clk,
	input wire logic [3:0] hold_low,
	// pins from the engine
	input wire logic zone_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_lower_n,
	input wire logic [19:0] ext_address_bus,
	input wire logic [31:0] data_out,
	// answers
	output logic [31:0] data_in,
	output logic ext_ready_in
);
	logic [31:0] mem_r [4];
	logic [31:0] last_r;
	logic [3:0] cnt_r = 4'h0;
	// ready held low
	// counts strobe cycles; saturates so a long hold ends in ready
	always_ff @(posedge tim_clk) begin
		if (read_strobe_n && write_strobe_lower_n) begin
			cnt_r <= 4'h0;
		end else if (cnt_r != 4'hF) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
	assign ext_ready_in = (cnt_r >= hold_low);
	// store writes; a released bus shows the inverse of its last value
	always_ff @(posedge tim_clk) begin
		if (!write_strobe_lower_n && !zone_select_n) begin
			mem_r[ext_address_bus[1:0]] <= data_out;
		end
		last_r <= data_in;
	end
	assign data_in = !read_strobe_n ? mem_r[ext_address_bus[1:0]] : ~last_r;
endmodule

//--- tb/ebrwc_top_tb.sv
/* self-checking bench: register access over the bus, pin timing by counting.
   assumes the memory model as far side and a free timing clock. */
`timescale 1ns/1ns
module ebrwc_top_tb;
	import ebrwc_pkg::*;
	logic clk, rst, tim_clk, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, din, dout;
	logic [3:0] wstrb, hold;
	logic [1:0] bresp, rresp, r;
	logic bclk, cs_n, rd_n, wel_n, weu_n, rnw, oe, rdy;
	logic [19:0] addr;
	logic [15:0] act_c = 16'h0, cs_c = 16'h0, up_c = 16'h0;
	int errors = 0, n_checks = 0;
	ebrwc_top uut (.clk, .rst, .tim_clk, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .bus_clock_out(bclk), .zone_select_n(cs_n), .ext_address_bus(addr),
		.read_strobe_n(rd_n), .write_strobe_lower_n(wel_n), .write_strobe_upper_n(weu_n), .read_not_write(rnw),
		.data_out(dout), .data_oe(oe), .data_in(din), .ext_ready_in(rdy));
	ebrwc_mem_model mem (.tim_clk, .hold_low(hold), .zone_select_n(cs_n), .read_strobe_n(rd_n),
		.write_strobe_lower_n(wel_n), .ext_address_bus(addr), .data_out(dout), .data_in(din), .ext_ready_in(rdy));
	// clocks, unrelated in phase
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		tim_clk = 0;
		#13;
		forever #80 tim_clk = ~tim_clk;
	end
	// free-running pin counters; differences give one access's lengths
	always @(posedge tim_clk) begin
		if (!rd_n || !wel_n) act_c <= act_c + 16'h1;
		if (!cs_n) cs_c <= cs_c + 16'h1;
		if (!weu_n) up_c <= up_c + 16'h1;
	end
	task automatic wrap_up;
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// bus write: both items offered together, each released at the edge that takes it
	task automatic axw(logic [7:0] a, logic [31:0] d);
		logic aw_go, w_go, b_go;
		@(posedge clk);
		aw_go = 1'b1;
		w_go = 1'b1;
		b_go = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// the response cannot come before both items are taken
		while (b_go) begin
			@(posedge clk);
			if (aw_go && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw_go = 1'b0;
			end
			if (w_go && wready === 1'b1) begin
				wvalid <= 1'b0;
				w_go = 1'b0;
			end
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				b_go = 1'b0;
			end
		end
	endtask
	task automatic axr(logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		araddr <= a; arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		@(posedge clk);
		rready <= 1'b1;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata; r = rresp; rready <= 1'b0;
	endtask
	initial begin
		#200_000;
		errors++;
		wrap_up;
	end
	initial begin
		logic [31:0] cs, v, s, wd, exp_rd;
		logic [15:0] a0, c0, u0;
		logic [6:0] tv;
		int n, ok;
		// fields: ctl lead act trail rd hold n
		static logic [31:0] cases [11] = '{32'h8131_0F30, 32'h8000_1F10, 32'h9131_1030, 32'h9131_1450, 32'h9221_0560,
			32'h9131_0030, 32'hB131_1030, 32'hB131_0570, 32'h0121_0020, 32'hC121_1020, 32'hC121_1020};
		rst = 1'b1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
		awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF; hold = 4'h0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge tim_clk);
		axr(EBRWC_OFF_CTRL, v);
		chk("ctrl reset", 32'h8, v);
		axr(EBRWC_OFF_TIMING, v);
		chk("timing reset", 32'h7F7F, v);
		axr(8'h1C, v);
		chk("unmapped read", 32'(EBRWC_RESP_SLVERR), 32'(r));
		axw(8'h1C, 32'h1);
		chk("unmapped write", 32'(EBRWC_RESP_SLVERR), 32'(r));
		ok = 0;
		foreach (cases[i]) begin
			cs = cases[i];
			wd = 32'h5A3C_0F00 + 32'(i);
			tv = {cs[17:16], cs[22:20], cs[25:24]};
			axw(EBRWC_OFF_CTRL, {28'h0, cs[31:28]});
			axw(EBRWC_OFF_TIMING, {17'h0, tv, 1'b0, tv});
			axw(EBRWC_OFF_ADDR, 32'h0_0005);
			axw(EBRWC_OFF_WDATA, wd);
			hold <= cs[11:8];
			a0 = act_c; c0 = cs_c; u0 = up_c;
			axw(EBRWC_OFF_CMD, {31'h0, cs[12]});
			for (int k = 0; k < 200; k++) begin
				axr(EBRWC_OFF_STATUS, s);
				if (s[0] === 1'b0) break;
			end
			chk("busy cleared", 32'h0, {31'h0, s[0]});
			repeat (2) @(posedge tim_clk);
			n = int'(cs[7:4]);
			v = 32'(act_c - a0);
			// async waits lag by the synchroniser, so a window is allowed
			if (cs[29] && cs[11:8] != 4'h0)
				chk("async stretch", 32'h1, 32'(v >= n && v <= n + 4));
			else
				chk("strobe cycles", n, v);
			if (!cs[29] || cs[11:8] == 4'h0)
				chk("select cycles", (cs[25:24] == 0 ? 1 : cs[25:24]) + n + cs[17:16], 32'(cs_c - c0));
			chk("upper strobe", (!cs[12] && cs[31]) ? v : 32'h0, 32'(up_c - u0));
			if (cs[12] && ok) begin
				axr(EBRWC_OFF_RDATA, v);
				chk("read data", cs[31] ? exp_rd : {16'h0, exp_rd[15:0]}, v);
			end
			if (!cs[12]) begin
				ok = 1;
				exp_rd = wd;
			end
		end
		wrap_up;
	end
endmodule
